// ===== logic/ctsc_defines.vh
`ifndef CTSC_DEFINES_VH
`define CTSC_DEFINES_VH

// Register offsets on the plain register port
`define CTSC_ADDR_SYSCTL2 8'h00
`define CTSC_ADDR_TBCTL 8'h04
`define CTSC_ADDR_STATUS 8'h08

// system_control_two fields
`define CTSC_SC2_SYS_CLK_SELECT 0
`define CTSC_SC2_IDLE 1
`define CTSC_SC2_HALT 2

// time_base_control fields
`define CTSC_TB_DV7 0
`define CTSC_TB_SRC_LO 1
`define CTSC_TB_SRC_HI 3
`define CTSC_TB_EN 4

// Reset values
`define CTSC_SC2_RESET 8'h00
`define CTSC_TB_RESET 8'h00

// Divider geometry
`define CTSC_PRE_W 2
`define CTSC_PRE_MAX 2'h3
`define CTSC_LO_W 6
`define CTSC_LO_MAX 6'h3F
`define CTSC_HI_W 15
`define CTSC_DIV_W 21
`define CTSC_TBT_BASE 5'h09
`define CTSC_DVO_BIT 4

// Operating modes
`define CTSC_M_RUN 2'h0
`define CTSC_M_IDLE 2'h1
`define CTSC_M_DEEP 2'h2

// Machine cycle limits
`define CTSC_MC_MIN 4'h1
`define CTSC_MC_MAX 4'hA
`define CTSC_ST_LAST 2'h3

`endif

// ===== logic/ctsc_top.v
`timescale 1ns/1ps
// Function
// [R1] Two-stage prescaler feeding twenty-one-stage divider chain
// [R2] Prescaler and divider cleared at reset, stop
// [R3] Stage seven clock chosen by mode, selects
// [R4] Software never sets stage-seven select in single-clock
// [R5] Stage-seven select set only after stable oscillator
// [R6] Low-speed modes feed low clock to stage seven
// [R7] Stop warm-up after stop entered from normal run feeds stage six into seven
// [R8] Machine cycle is four one-clock states
// [R9] Instructions last one to ten machine cycles
// [R10] Single-clock: cycle equals four high-frequency periods
// [R11] Single-clock: resonator pins become port pins
// [R12] Reset enters single-clock normal run mode
// [R13] Idle halts CPU, watchdog; peripherals keep running
// [R14] Idle bit enters idle; interrupt wakes
// [R15] Wake with master enable takes interrupt
// [R16] Wake without master enable resumes next instruction
// [R17] Halt bit enters deep idle; time base runs
// [R18] Deep idle resumes on time base falling edge
// [R19] Deep idle ignores time base enable; exits to run
// [R20] Time base service needs three enables set
// [R21] Deep idle with time base sets latch
// [R22] System clock select moves CPU to low clock
// [R23] Divider counts continuously through idle modes
`include "ctsc_defines.vh"

module ctsc_top (
	input wire clock, // High-frequency basic clock, 200 MHz
	input wire rst, // Synchronous reset, active high
	input wire [7:0] reg_addr, // Register address
	input wire [7:0] reg_wdata, // Register write data
	input wire reg_wr, // Write strobe
	input wire reg_rd, // Read strobe
	output reg [7:0] reg_rdata_q, // Read data, cycle after strobe
	input wire low_freq_osc_in, // Low-frequency clock pin
	input wire stop_enter, // Pulse: stop mode entered
	input wire stop_release, // Pulse: stop mode released
	input wire warmup_busy, // Level: stop warm-up running
	input wire irq_any, // Level: any interrupt request
	input wire int_master_enable, // Interrupt master enable
	input wire time_base_int_enable, // Time base individual enable
	input wire time_base_int_ack, // Pulse: latch cleared by CPU
	input wire [3:0] instr_cycles, // Machine cycles of next instr
	output reg [`CTSC_DIV_W-1:0] divider_q, // Divider stages 1 to 21
	output reg [1:0] mc_state_q, // Machine cycle state S0..S3
	output reg main_clk_en_q, // Main system clock enable
	output reg mc_end_q, // Pulse: cycle end, high with the next S0
	output reg instr_done_q, // Pulse: instruction finished
	output reg [1:0] mode_q, // Operating mode
	output reg cpu_clk_en_q, // CPU clock gate
	output reg wdt_clk_en_q, // Watchdog clock gate
	output reg periph_clk_en_q, // Peripheral clock gate
	output reg tbt_clk_en_q, // Time base timer clock gate
	output reg wake_take_int_q, // Pulse: wake and take interrupt
	output reg wake_resume_q, // Pulse: wake and resume next
	output reg time_base_int_latch_q, // Time base interrupt latch
	output reg tb_int_service_q, // Time base interrupt serviced
	output reg xt_pins_gpio_q, // Resonator pins act as ports
	output reg divider_pulse_out_q // Divider output pulse
);

	reg [7:0] sysctl_q;
	reg [7:0] tbctl_q;
	reg [`CTSC_PRE_W-1:0] pre_q;
	reg lf_s1_q;
	reg lf_s2_q;
	reg lf_s3_q;
	reg from_normal_q;
	reg tb_src_prev_q;
	reg deep_tbe_q;
	reg [3:0] mc_cnt_q;
	reg [3:0] mc_len_q;
	reg idle_req;
	reg halt_req;
	reg [1:0] mode_d;
	wire sys_clk_select;
	wire div_stage7_clk_select;
	wire [2:0] time_base_src_select;
	wire time_base_enable;
	wire div_clear;
	wire pre_tick;
	wire st6_tick;
	wire lf_tick;
	reg st7_tick;
	wire state_tick;
	wire [4:0] tb_bit_idx;
	wire tb_src;
	wire tb_fall;
	wire deep_exit;
	wire [3:0] len_clamped;

	assign sys_clk_select = sysctl_q[`CTSC_SC2_SYS_CLK_SELECT];
	assign div_stage7_clk_select = tbctl_q[`CTSC_TB_DV7];
	assign time_base_src_select = tbctl_q[`CTSC_TB_SRC_HI:`CTSC_TB_SRC_LO];
	assign time_base_enable = tbctl_q[`CTSC_TB_EN];

	// Register writes; idle and halt requests are one-cycle strobes
	always @(posedge clock) begin
		idle_req <= 1'b0;
		halt_req <= 1'b0;
		if (rst) begin
			sysctl_q <= `CTSC_SC2_RESET; // [R12]
			tbctl_q <= `CTSC_TB_RESET;
		end else if (reg_wr) begin
			case (reg_addr)
			`CTSC_ADDR_SYSCTL2: begin
				sysctl_q[`CTSC_SC2_SYS_CLK_SELECT] <= reg_wdata[`CTSC_SC2_SYS_CLK_SELECT];
				idle_req <= reg_wdata[`CTSC_SC2_IDLE]; // [R14]
				halt_req <= reg_wdata[`CTSC_SC2_HALT]; // [R17]
			end
			`CTSC_ADDR_TBCTL: begin
				tbctl_q <= {3'h0, reg_wdata[4:0]};
			end
			default: begin
				sysctl_q <= sysctl_q;
			end
			endcase
		end
	end

	// Read data, one cycle after the strobe; unmapped reads zero
	always @(posedge clock) begin
		if (rst) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
			`CTSC_ADDR_SYSCTL2: reg_rdata_q <= {7'h00, sys_clk_select};
			`CTSC_ADDR_TBCTL: reg_rdata_q <= tbctl_q;
			`CTSC_ADDR_STATUS: reg_rdata_q <= {3'h0,
				time_base_int_latch_q, mc_state_q, mode_q};
			default: reg_rdata_q <= 8'h00;
			endcase
		end else begin
			reg_rdata_q <= 8'h00;
		end
	end

	// Low-frequency pin: two-flop synchroniser, then edge detect
	always @(posedge clock) begin
		if (rst) begin
			lf_s1_q <= 1'b0;
			lf_s2_q <= 1'b0;
			lf_s3_q <= 1'b0;
		end else begin
			lf_s1_q <= low_freq_osc_in;
			lf_s2_q <= lf_s1_q;
			lf_s3_q <= lf_s2_q;
		end
	end
	assign lf_tick = lf_s2_q & ~lf_s3_q;

	// Divider chain ticks
	assign div_clear = stop_enter | stop_release; // [R2]
	assign pre_tick = (pre_q == `CTSC_PRE_MAX);
	assign st6_tick = pre_tick &
		(divider_q[`CTSC_LO_W-1:0] == `CTSC_LO_MAX);

	// Stage seven clock source
	always @* begin
		if (warmup_busy && from_normal_q) begin
			st7_tick = st6_tick; // [R7]
		end else if (sys_clk_select) begin
			st7_tick = lf_tick; // [R6]
		end else if (div_stage7_clk_select) begin
			st7_tick = lf_tick; // [R3] [R5]
		end else begin
			st7_tick = st6_tick; // [R3] [R4]
		end
	end

	// Prescaler and divider; never gated by idle modes
	always @(posedge clock) begin
		if (rst || div_clear) begin
			pre_q <= {`CTSC_PRE_W{1'b0}}; // [R2]
			divider_q <= {`CTSC_DIV_W{1'b0}}; // [R2]
		end else begin
			pre_q <= pre_q + 1'b1; // [R1] [R23]
			if (pre_tick) begin
				divider_q[`CTSC_LO_W-1:0] <=
					divider_q[`CTSC_LO_W-1:0] + 1'b1; // [R1]
			end
			if (st7_tick) begin
				divider_q[`CTSC_DIV_W-1:`CTSC_LO_W] <=
					divider_q[`CTSC_DIV_W-1:`CTSC_LO_W] + 1'b1; // [R1]
			end
		end
	end

	// Remember whether stop was entered from normal run
	always @(posedge clock) begin
		if (rst) begin
			from_normal_q <= 1'b0;
		end else if (stop_enter) begin
			from_normal_q <= ~sys_clk_select; // [R7]
		end
	end

	// Main system clock: every fc cycle, or each rising fs edge in low speed
	assign state_tick = sys_clk_select ? lf_tick : 1'b1; // [R10] [R22]

	// Machine cycle states and instruction cycle counter
	assign len_clamped = (instr_cycles < `CTSC_MC_MIN) ? `CTSC_MC_MIN :
		(instr_cycles > `CTSC_MC_MAX) ? `CTSC_MC_MAX : instr_cycles;
	always @(posedge clock) begin
		if (rst) begin
			mc_state_q <= 2'h0;
			main_clk_en_q <= 1'b0;
			mc_end_q <= 1'b0;
			instr_done_q <= 1'b0;
			mc_cnt_q <= 4'h1;
			mc_len_q <= `CTSC_MC_MIN;
		end else begin
			main_clk_en_q <= state_tick;
			mc_end_q <= 1'b0;
			instr_done_q <= 1'b0;
			if (state_tick) begin
				mc_state_q <= mc_state_q + 1'b1; // [R8]
				if (mc_state_q == `CTSC_ST_LAST) begin
					mc_end_q <= 1'b1; // [R8]
					if (cpu_clk_en_q) begin
						if (mc_cnt_q >= mc_len_q) begin
							instr_done_q <= 1'b1; // [R9]
							mc_cnt_q <= 4'h1;
							mc_len_q <= len_clamped; // [R9]
						end else begin
							mc_cnt_q <= mc_cnt_q + 1'b1; // [R9]
						end
					end
				end
			end
		end
	end

	// Time base source bit and its falling edge
	assign tb_bit_idx = `CTSC_TBT_BASE + {2'h0, time_base_src_select};
	assign tb_src = divider_q[tb_bit_idx];
	assign tb_fall = tb_src_prev_q & ~tb_src;
	assign deep_exit = (mode_q == `CTSC_M_DEEP) && tb_fall; // [R18]
	always @(posedge clock) begin
		if (rst) begin
			tb_src_prev_q <= 1'b0;
		end else begin
			tb_src_prev_q <= tb_src;
		end
	end

	// Next operating mode
	always @* begin
		case (mode_q)
		`CTSC_M_RUN: begin
			if (halt_req) begin
				mode_d = `CTSC_M_DEEP; // [R17] [R19]
			end else if (idle_req) begin
				mode_d = `CTSC_M_IDLE; // [R14]
			end else begin
				mode_d = `CTSC_M_RUN;
			end
		end
		`CTSC_M_IDLE: begin
			mode_d = irq_any ? `CTSC_M_RUN : `CTSC_M_IDLE; // [R14]
		end
		`CTSC_M_DEEP: begin
			mode_d = deep_exit ? `CTSC_M_RUN : `CTSC_M_DEEP; // [R19]
		end
		default: begin
			mode_d = `CTSC_M_RUN;
		end
		endcase
	end

	// Mode register, clock gates and wake outcomes
	always @(posedge clock) begin
		if (rst) begin
			mode_q <= `CTSC_M_RUN; // [R12]
			cpu_clk_en_q <= 1'b1;
			wdt_clk_en_q <= 1'b1;
			periph_clk_en_q <= 1'b1;
			tbt_clk_en_q <= 1'b1;
			wake_take_int_q <= 1'b0;
			wake_resume_q <= 1'b0;
			deep_tbe_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			cpu_clk_en_q <= (mode_d == `CTSC_M_RUN); // [R13] [R18]
			wdt_clk_en_q <= (mode_d == `CTSC_M_RUN); // [R13]
			periph_clk_en_q <= (mode_d != `CTSC_M_DEEP); // [R13] [R18]
			tbt_clk_en_q <= 1'b1; // [R17]
			wake_take_int_q <= (mode_q == `CTSC_M_IDLE) && irq_any &&
				int_master_enable; // [R15]
			wake_resume_q <= (mode_q == `CTSC_M_IDLE) && irq_any &&
				~int_master_enable; // [R16]
			if (mode_q == `CTSC_M_RUN && halt_req) begin
				deep_tbe_q <= time_base_enable; // [R21]
			end
		end
	end

	// Time base interrupt latch; a set wins over the acknowledge
	always @(posedge clock) begin
		if (rst) begin
			time_base_int_latch_q <= 1'b0;
		end else if (deep_exit && deep_tbe_q) begin
			time_base_int_latch_q <= 1'b1; // [R21]
		end else if (time_base_int_ack) begin
			time_base_int_latch_q <= 1'b0;
		end
	end

	// Service qualifier, port pin role and divider output
	always @(posedge clock) begin
		if (rst) begin
			tb_int_service_q <= 1'b0;
			xt_pins_gpio_q <= 1'b1;
			divider_pulse_out_q <= 1'b0;
		end else begin
			tb_int_service_q <= time_base_int_latch_q &&
				int_master_enable && time_base_int_enable &&
				time_base_enable && (mode_q == `CTSC_M_RUN); // [R20]
			xt_pins_gpio_q <= ~(sys_clk_select |
				div_stage7_clk_select); // [R11]
			divider_pulse_out_q <= divider_q[`CTSC_DVO_BIT];
		end
	end

endmodule // ctsc_top

// ===== testbench/ctsc_cpu_model.sv
`timescale 1ns/1ps
`include "ctsc_defines.vh"
module ctsc_cpu_model (
	input wire clock, // Clock
	input wire rst, // Reset
	input wire irq_req, // Bench asks for an interrupt
	input wire [1:0] mode_q, // Block mode
	input wire tb_int_service_q, // Time base serviced
	input wire instr_done_q, // Instruction finished
	output reg irq_any, // Interrupt request
	output reg time_base_int_ack, // Latch clear pulse
	output reg [3:0] instr_cycles // Next instruction length
);
	// Request held until run, ack on alternate cycles after service, lengths 1 to 10
	always @(posedge clock) begin
		if (rst) begin
			irq_any <= 1'b0;
			time_base_int_ack <= 1'b0;
			instr_cycles <= `CTSC_MC_MIN;
		end else begin
			irq_any <= irq_req || (irq_any && mode_q != `CTSC_M_RUN);
			time_base_int_ack <= tb_int_service_q && !time_base_int_ack;
			if (instr_done_q) begin
				instr_cycles <= (instr_cycles == `CTSC_MC_MAX) ?
					`CTSC_MC_MIN : instr_cycles + 4'h1;
			end
		end
	end
endmodule // ctsc_cpu_model

// ===== testbench/ctsc_monitor.sv
`timescale 1ns/1ps
`include "ctsc_defines.vh"
module ctsc_monitor (
	input wire clock, // Clock
	input wire rst, // Reset
	input wire stop_enter, // Stop entry
	input wire stop_release, // Stop exit
	input wire irq_any, // Interrupt
	input wire int_master_enable, // Master enable
	input wire time_base_int_enable, // Time base enable
	input wire [20:0] divider_q, // Divider
	input wire [1:0] mc_state_q, // State
	input wire [1:0] mode_q, // Mode
	input wire cpu_clk_en_q, // CPU gate
	input wire wdt_clk_en_q, // Watchdog gate
	input wire periph_clk_en_q, // Peripheral gate
	input wire tbt_clk_en_q, // Time base gate
	input wire wake_take_int_q, // Wake to service
	input wire wake_resume_q, // Wake to resume
	input wire time_base_int_latch_q, // Latch
	input wire tb_int_service_q, // Service
	input wire xt_pins_gpio_q // Port pins
);
	// One clock domain, so shared clock and reset
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	rst_clear_a: assert property ($fell(rst) |->
		divider_q == 0 && mode_q == `CTSC_M_RUN && xt_pins_gpio_q)
		else $error("state not cleared by reset");
	stop_clear_a: assert property (stop_enter || stop_release |=>
		divider_q == 0) else $error("divider not cleared at stop");
	div_runs_a: assert property ($stable(divider_q) [*6] |->
		divider_q == 0) else $error("divider stalled");
	state_seq_a: assert property ($changed(mc_state_q) |->
		mc_state_q == $past(mc_state_q) + 2'h1)
		else $error("machine state skipped");
	run_gate_a: assert property (mode_q == `CTSC_M_RUN |->
		cpu_clk_en_q && wdt_clk_en_q && periph_clk_en_q && tbt_clk_en_q)
		else $error("gate off in run");
	idle_gate_a: assert property (mode_q == `CTSC_M_IDLE |->
		!cpu_clk_en_q && !wdt_clk_en_q && periph_clk_en_q)
		else $error("wrong gates in idle");
	deep_gate_a: assert property (mode_q == `CTSC_M_DEEP |->
		!cpu_clk_en_q && !periph_clk_en_q && tbt_clk_en_q)
		else $error("wrong gates in deep idle");
	idle_wake_a: assert property (mode_q == `CTSC_M_IDLE && irq_any |=>
		mode_q == `CTSC_M_RUN) else $error("idle did not wake");
	wake_take_a: assert property (mode_q == `CTSC_M_IDLE && irq_any &&
		int_master_enable |-> ##[1:2] wake_take_int_q)
		else $error("wake without service");
	wake_res_a: assert property (mode_q == `CTSC_M_IDLE && irq_any &&
		!int_master_enable |-> ##[1:2] wake_resume_q)
		else $error("wake without resume");
	tb_service_a: assert property (tb_int_service_q |->
		$past(time_base_int_latch_q) && $past(int_master_enable) &&
		$past(time_base_int_enable)) else $error("service not enabled");
endmodule // ctsc_monitor

// ===== testbench/tb_ctsc_top.sv
`timescale 1ns/1ps
`include "ctsc_defines.vh"
module tb_ctsc_top;
	logic clock = 0, rst = 1, reg_wr = 0, reg_rd = 0, low_freq_osc_in = 0;
	logic stop_enter = 0, stop_release = 0, warmup_busy = 0, irq_req = 0;
	logic int_master_enable = 0, time_base_int_enable = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	logic tk, rs, sv, lt;
	wire [7:0] reg_rdata_q;
	wire [20:0] divider_q;
	wire [3:0] instr_cycles;
	wire [1:0] mc_state_q, mode_q;
	wire main_clk_en_q, mc_end_q, instr_done_q, cpu_clk_en_q, wdt_clk_en_q;
	wire periph_clk_en_q, tbt_clk_en_q, wake_take_int_q, wake_resume_q;
	wire time_base_int_latch_q, tb_int_service_q, xt_pins_gpio_q;
	wire divider_pulse_out_q, irq_any, time_base_int_ack;
	int n_errors = 0, n_checks = 0;
	ctsc_top u_ctsc_top (.*);
	ctsc_cpu_model u_ctsc_cpu_model (.*);
	// Clock and hang guard
	always #2.5 clock = ~clock;
	initial begin
		#200000;
		n_errors++;
		conclude;
	end
	task chk(input logic [20:0] got, input logic [20:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task conclude;
		if (n_errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata_q;
	endtask
	// Bounded wait for a mode, noting wake pulses on the way
	task wmode(input logic [1:0] m);
		tk = 0;
		rs = 0;
		sv = 0;
		for (int i = 0; i < 12000 && mode_q !== m; i++) begin
			@(posedge clock);
			#1 tk |= wake_take_int_q;
			rs |= wake_resume_q;
		end
		lt = time_base_int_latch_q;
		chk(mode_q, m);
		repeat (4) begin
			@(posedge clock);
			#1 tk |= wake_take_int_q;
			rs |= wake_resume_q;
			sv |= tb_int_service_q;
		end
	endtask
	task t_reset;
		logic [7:0] d;
		chk(mode_q, `CTSC_M_RUN);
		chk(xt_pins_gpio_q, 1'b1);
		rd(`CTSC_ADDR_STATUS, d);
		chk(d[4], 1'b0);
		rd(8'h0C, d);
		chk(d, 8'h00);
	endtask
	task t_regs;
		logic [7:0] d;
		logic [1:0] s;
		wr(`CTSC_ADDR_TBCTL, 8'h1E);
		rd(`CTSC_ADDR_TBCTL, d);
		chk(d, 8'h1E);
		wr(`CTSC_ADDR_SYSCTL2, 8'h01);
		rd(`CTSC_ADDR_SYSCTL2, d);
		chk(d, 8'h01);
		s = mc_state_q;
		repeat (20) @(posedge clock);
		#1 chk(mc_state_q, s);
		chk(main_clk_en_q, 1'b0);
		wr(`CTSC_ADDR_SYSCTL2, 8'h00);
		repeat (3) @(posedge clock);
		#1 s = mc_state_q;
		repeat (4) begin
			@(posedge clock);
			#1 s = s + 2'h1;
			chk(mc_state_q, s);
			chk(mc_end_q, s == 2'h0);
			chk(main_clk_en_q, 1'b1);
		end
	endtask
	task t_idle;
		for (int k = 1; k >= 0; k--) begin
			int_master_enable <= k[0];
			wr(`CTSC_ADDR_SYSCTL2, 8'h02);
			@(posedge clock);
			#1 chk(mode_q, `CTSC_M_IDLE);
			chk({cpu_clk_en_q, wdt_clk_en_q, periph_clk_en_q}, 3'h1);
			irq_req <= 1'b1;
			@(posedge clock);
			irq_req <= 1'b0;
			wmode(`CTSC_M_RUN);
			chk({tk, rs}, {k[0], !k[0]});
		end
	endtask
	task t_deep;
		logic [20:0] dv;
		int_master_enable <= 1'b1;
		time_base_int_enable <= 1'b1;
		for (int k = 1; k >= 0; k--) begin
			wr(`CTSC_ADDR_TBCTL, {3'h0, k[0], 4'h0});
			wr(`CTSC_ADDR_SYSCTL2, 8'h06);
			@(posedge clock);
			#1 chk(mode_q, `CTSC_M_DEEP);
			chk({cpu_clk_en_q, periph_clk_en_q, tbt_clk_en_q}, 3'h1);
			dv = divider_q;
			repeat (8) @(posedge clock);
			#1 chk(divider_q != dv, 1'b1);
			wmode(`CTSC_M_RUN);
			chk(lt, k[0]);
			chk(sv, k[0]);
		end
	endtask
	task t_stop;
		repeat (50) @(posedge clock);
		stop_enter <= 1'b1;
		@(posedge clock);
		stop_enter <= 1'b0;
		#1 chk(divider_q, 21'h0);
		warmup_busy <= 1'b1;
		stop_release <= 1'b1;
		@(posedge clock);
		stop_release <= 1'b0;
		#1 chk(divider_q, 21'h0);
		repeat (300) @(posedge clock);
		#1 chk(divider_q[20:6] != 0, 1'b1);
		warmup_busy <= 1'b0;
		lt = divider_q[4];
		@(posedge clock);
		#1 chk(divider_pulse_out_q, lt);
	endtask
	// Reset, then the scenarios in turn
	initial begin
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		#1 t_reset;
		t_regs;
		t_idle;
		t_deep;
		t_stop;
		conclude;
	end
endmodule // tb_ctsc_top
bind ctsc_top ctsc_monitor u_ctsc_monitor (.*);
